// [inc/eeprom_loader_params.svh]
`ifndef EEPROM_LOADER_PARAMS_SVH
`define EEPROM_LOADER_PARAMS_SVH

// ************************************************************
// Register byte offsets on the APB.
// ************************************************************
`define ADDR_CFG_LO 8'h00
`define ADDR_CFG_HI 8'h04
`define ADDR_TGT 8'h08
`define ADDR_EVENT 8'h0C
`define ADDR_MASK 8'h10
`define ADDR_ERRCNT 8'h14
`define ADDR_CTRL 8'h18

// ************************************************************
// Load configuration word: reset value, writable bits, fields.
// ************************************************************
`define CFG_RESET 64'h0009_61C2_2580_0A04
`define CFG_WMASK 64'h00FF_FFFF_FFF0_7FFF
`define F_FALL 55:44
`define F_RISE 43:32
`define F_CYCLE 31:20
`define F_DRV 14:13
`define F_EXT 12
`define F_ASIZE 11
`define F_LEN 10:7
`define F_LOADEN 6
`define F_SPEED 5:4
`define F_RETRY 3:0

// ************************************************************
// Other registers, events and timing constants.
// ************************************************************
`define TGT_RESET 7'h50
`define EV_CRC 0
`define EV_FAIL 1
`define EV_BAD 3
`define EV_W 4
`define CTRL_START 0
`define ERRCNT_MAX 4'hF
`define SPEED_400K 2'h1
`define SPEED_1M 2'h2
`define DIV_400K 12'h004
`define DIV_1M 12'h00A
`define LEN_MAX 4'h9
`define CAP_BASE 17'h00080

`endif

// [inc/eeprom_loader_pkg.sv]
package eeprom_loader_pkg;
    typedef enum logic [2:0] {S_IDLE, S_OTPC, S_EEC, S_OTPU, S_EEU} seq_state_t;
    typedef enum logic [2:0] {E_IDLE, E_WAIT_SDA, E_START, E_HOLD, E_BIT, E_RSTART, E_STOP} eng_state_t;
    typedef enum logic [2:0] {K_CTRLW, K_ADDRH, K_ADDRL, K_CTRLR, K_DATA} byte_kind_t;
endpackage

// [inc/scl_timing_if.sv]
`timescale 1ns/1ps
// Carries the SCL timing settings to the period timer and its edge events back.
interface scl_timing_if;
    logic [11:0] cycle;
    logic [11:0] rise;
    logic [11:0] fall;
    logic [1:0] speed;
    logic run;
    logic rise_ev;
    logic fall_ev;
    logic wrap_ev;
    modport timer (input cycle, rise, fall, speed, run, output rise_ev, fall_ev, wrap_ev);
    modport user (output cycle, rise, fall, speed, run, input rise_ev, fall_ev, wrap_ev);
endinterface

// [logic/eeprom_config_loader.sv]
`timescale 1ns/1ps
`include "eeprom_loader_params.svh"
// Contract
// - SCL period is a 12-bit count of system clocks, reset 0x258.
// - SCL rises when the down counter reaches the 12-bit rise point.
// - SCL falls when the down counter reaches the 12-bit fall point.
// - Speed 1 and 2 divide the counts by 4 and by 10.
// - Drive select reaches the pads only while the master is active.
// - Extended mode puts address bits 10:8 in the target byte.
// - Address-size bit picks one or two address bytes outside extended mode (always one there), reset two.
// - Size code gives capacity 128 bytes shifted by code, capped at code 9, reset 2KB.
// - Order OTP common, EEPROM common, OTP user, EEPROM user, gated by enable.
// - Enable delivered by each OTP stage decides the following EEPROM stage.
// - Retry up to the programmed count, then flag load failure.
// - Seven-bit target address of the memory, reset 0x50.
// - No acknowledge sets not-detected instead of load failure.
// - CRC error counter saturates at 0xF, writable by software.
module eeprom_config_loader (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic otp_common_valid,
    input wire logic otp_user_valid,
    input wire logic otp_load_en,
    input wire logic crc_bad,
    output logic scl_out,
    output logic scl_oe,
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe,
    output logic [1:0] pad_drive,
    output logic [7:0] cfg_byte,
    output logic cfg_byte_valid,
    output logic cfg_stage_user,
    output logic load_busy,
    output logic irq
);
    import eeprom_loader_pkg::*;

    // ************************************************************
    // Registers and internal state.
    // ************************************************************
    logic [63:0] cfg_q;
    logic [6:0] tgt_q;
    logic [`EV_W-1:0] ev_q, ev_d, mask_q, ev_set;
    logic [3:0] errcnt_q, attempt_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, irq_q, pin_low_q;
    logic sda_s1_q, sda_s_q;
    seq_state_t seq_q;
    eng_state_t eng_q;
    byte_kind_t kind_q;
    logic [8:0] sh_q;
    logic [7:0] rx_q, byte_q;
    logic [3:0] bit_q;
    logic [15:0] addr_q, left_q;
    logic scl_low_q, sda_drv_q, nack_q, done_q, go_q, valid_q, user_q, busy_q;
    logic [1:0] drive_q;

    scl_timing_if tif ();
    scl_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .t(tif)
    );

    // ************************************************************
    // APB decode and read mux.
    // ************************************************************
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pready_q && pwrite;
    wire hit_lo = (paddr == `ADDR_CFG_LO);
    wire hit_hi = (paddr == `ADDR_CFG_HI);
    wire hit_tgt = (paddr == `ADDR_TGT);
    wire hit_ev = (paddr == `ADDR_EVENT);
    wire hit_mask = (paddr == `ADDR_MASK);
    wire hit_cnt = (paddr == `ADDR_ERRCNT);
    wire hit_ctrl = (paddr == `ADDR_CTRL);
    wire mapped = hit_lo | hit_hi | hit_tgt | hit_ev | hit_mask | hit_cnt | hit_ctrl;
    wire [31:0] rd_mux = hit_lo ? cfg_q[31:0] :
                         hit_hi ? cfg_q[63:32] :
                         hit_tgt ? {25'h0, tgt_q} :
                         hit_ev ? {28'h0, ev_q} :
                         hit_mask ? {28'h0, mask_q} :
                         hit_cnt ? {28'h0, errcnt_q} :
                         hit_ctrl ? {29'h0, seq_q != S_IDLE, eng_q != E_IDLE, 1'b0} : 32'h0;
    wire [63:0] cfg_wr = {hit_hi ? pwdata : cfg_q[63:32], hit_lo ? pwdata : cfg_q[31:0]};

    // Read data and ready are registered at setup, so every access ends in its first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            if (setup) begin
                prdata_q <= rd_mux;
                pslverr_q <= !mapped;
            end
        end
    end

    // ************************************************************
    // Derived settings.
    // ************************************************************
    wire [3:0] len_code = (cfg_q[`F_LEN] > `LEN_MAX) ? `LEN_MAX : cfg_q[`F_LEN];
    wire [16:0] cap = `CAP_BASE << len_code;
    wire [15:0] half = cap[16:1];
    wire ext = cfg_q[`F_EXT];
    wire [7:0] ctrl_w = ext ? {tgt_q[6:3], addr_q[10:8], 1'b0} : {tgt_q, 1'b0};
    wire [7:0] ctrl_r = ext ? {tgt_q[6:3], addr_q[10:8], 1'b1} : {tgt_q, 1'b1};
    wire [3:0] tries = (cfg_q[`F_RETRY] == 4'h0) ? 4'h1 : cfg_q[`F_RETRY];
    wire last_try = (attempt_q + 4'h1) >= tries;
    wire fail = nack_q || crc_bad;
    wire stage_end = done_q && (!fail || last_try);
    wire rd = tif.rise_ev;
    wire fl = tif.fall_ev;
    wire wp = tif.wrap_ev;
    wire byte_end = (eng_q == E_BIT) && fl && (bit_q == 4'h8);
    assign tif.cycle = cfg_q[`F_CYCLE];
    assign tif.rise = cfg_q[`F_RISE];
    assign tif.fall = cfg_q[`F_FALL];
    assign tif.speed = cfg_q[`F_SPEED];
    assign tif.run = (eng_q != E_IDLE) && (eng_q != E_WAIT_SDA);

    // ************************************************************
    // Configuration, target, mask and error counter registers.
    // ************************************************************
    // OTP stages overwrite the enable bit after any software write in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= `CFG_RESET;
            tgt_q <= `TGT_RESET;
            mask_q <= '0;
            errcnt_q <= 4'h0;
        end else begin
            if (wr_en && (hit_lo || hit_hi)) begin
                cfg_q <= cfg_wr & `CFG_WMASK;
            end
            if ((seq_q == S_OTPC && otp_common_valid) || (seq_q == S_OTPU && otp_user_valid)) begin
                cfg_q[`F_LOADEN] <= otp_load_en;
            end
            if (wr_en && hit_tgt) begin
                tgt_q <= pwdata[6:0];
            end
            if (wr_en && hit_mask) begin
                mask_q <= pwdata[`EV_W-1:0];
            end
            if (wr_en && hit_cnt) begin
                errcnt_q <= pwdata[3:0];
            end else if (done_q && crc_bad && !nack_q && errcnt_q != `ERRCNT_MAX) begin
                errcnt_q <= errcnt_q + 4'h1;
            end
        end
    end

    // ************************************************************
    // Sticky events and interrupt.
    // ************************************************************
    assign ev_set[`EV_CRC] = done_q && crc_bad && !nack_q;
    assign ev_set[`EV_FAIL] = stage_end && fail && !nack_q;
    assign ev_set[`EV_BAD] = stage_end && nack_q;
    assign ev_set[2] = 1'b0;
    // A new event wins over a write-one-to-clear in the same cycle.
    assign ev_d = (ev_q & ~((wr_en && hit_ev) ? pwdata[`EV_W-1:0] : '0)) | ev_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_q <= '0;
            irq_q <= 1'b0;
        end else begin
            ev_q <= ev_d;
            irq_q <= |(ev_d & mask_q);
        end
    end

    // ************************************************************
    // Load sequence across OTP and EEPROM stages.
    // ************************************************************
    // Reset starts the startup load; a start write while idle repeats it as a dynamic load.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_q <= S_OTPC;
            attempt_q <= 4'h0;
            go_q <= 1'b0;
        end else begin
            go_q <= 1'b0;
            case (seq_q)
                S_IDLE: begin
                    if (wr_en && hit_ctrl && pwdata[`CTRL_START]) begin
                        seq_q <= S_OTPC;
                    end
                end
                S_OTPC, S_OTPU: begin
                    if ((seq_q == S_OTPC) ? otp_common_valid : otp_user_valid) begin
                        attempt_q <= 4'h0;
                        go_q <= otp_load_en;
                        if (seq_q == S_OTPC) begin
                            seq_q <= otp_load_en ? S_EEC : S_OTPU;
                        end else begin
                            seq_q <= otp_load_en ? S_EEU : S_IDLE;
                        end
                    end
                end
                default: begin
                    if (stage_end) begin
                        seq_q <= (seq_q == S_EEC) ? S_OTPU : S_IDLE;
                    end else if (done_q) begin
                        attempt_q <= attempt_q + 4'h1;
                        go_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Serial data synchroniser.
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_s1_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else begin
            sda_s1_q <= serial_data_pin_in;
            sda_s_q <= sda_s1_q;
        end
    end

    // ************************************************************
    // Byte engine: write address, repeated start, read the stage.
    // ************************************************************
    // Data changes at the counter wrap, mid low phase, and is sampled at the fall point.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng_q <= E_IDLE;
            kind_q <= K_CTRLW;
            sh_q <= 9'h1FF;
            rx_q <= 8'h00;
            bit_q <= 4'h0;
            addr_q <= 16'h0;
            left_q <= 16'h0;
            scl_low_q <= 1'b0;
            sda_drv_q <= 1'b0;
            nack_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (eng_q)
                E_IDLE: begin
                    if (go_q) begin
                        addr_q <= (seq_q == S_EEU) ? half : 16'h0;
                        left_q <= half;
                        nack_q <= 1'b0;
                        kind_q <= K_CTRLW;
                        eng_q <= E_WAIT_SDA;
                    end
                end
                E_WAIT_SDA: begin
                    if (sda_s_q) begin
                        sh_q <= {ctrl_w, 1'b1};
                        eng_q <= E_START;
                    end
                end
                E_START: begin
                    if (fl) begin
                        sda_drv_q <= 1'b1;
                        eng_q <= E_HOLD;
                    end
                end
                E_HOLD: begin
                    if (fl) begin
                        scl_low_q <= 1'b1;
                        bit_q <= 4'h0;
                        eng_q <= E_BIT;
                    end
                end
                E_BIT: begin
                    if (wp) begin
                        sda_drv_q <= !sh_q[8];
                    end
                    if (rd) begin
                        scl_low_q <= 1'b0;
                    end
                    if (fl) begin
                        scl_low_q <= 1'b1;
                        sh_q <= {sh_q[7:0], 1'b1};
                        bit_q <= bit_q + 4'h1;
                        if (bit_q != 4'h8) begin
                            rx_q <= {rx_q[6:0], sda_s_q};
                        end
                    end
                    if (byte_end) begin
                        bit_q <= 4'h0;
                        if (kind_q != K_DATA && sda_s_q) begin
                            nack_q <= 1'b1;
                            eng_q <= E_STOP;
                        end else if (kind_q == K_CTRLW) begin
                            kind_q <= (!ext && cfg_q[`F_ASIZE]) ? K_ADDRH : K_ADDRL;
                            sh_q <= (!ext && cfg_q[`F_ASIZE]) ? {addr_q[15:8], 1'b1} : {addr_q[7:0], 1'b1};
                        end else if (kind_q == K_ADDRH) begin
                            kind_q <= K_ADDRL;
                            sh_q <= {addr_q[7:0], 1'b1};
                        end else if (kind_q == K_ADDRL) begin
                            kind_q <= K_CTRLR;
                            sh_q <= {ctrl_r, 1'b1};
                            eng_q <= E_RSTART;
                        end else begin
                            if (kind_q == K_DATA) begin
                                left_q <= left_q - 16'h1;
                            end
                            kind_q <= K_DATA;
                            sh_q <= {8'hFF, (kind_q == K_DATA) ? (left_q <= 16'h2) : (left_q == 16'h1)};
                            if (kind_q == K_DATA && left_q == 16'h1) begin
                                eng_q <= E_STOP;
                            end
                        end
                    end
                end
                E_RSTART: begin
                    if (wp) begin
                        sda_drv_q <= 1'b0;
                    end
                    if (rd) begin
                        scl_low_q <= 1'b0;
                    end
                    if (fl) begin
                        sda_drv_q <= 1'b1;
                        eng_q <= E_HOLD;
                    end
                end
                default: begin
                    if (wp) begin
                        sda_drv_q <= 1'b1;
                    end
                    if (rd) begin
                        scl_low_q <= 1'b0;
                    end
                    if (fl) begin
                        sda_drv_q <= 1'b0;
                        done_q <= 1'b1;
                        eng_q <= E_IDLE;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Pins, data stream and pad drive.
    // ************************************************************
    // Pins are open drain, so the output level is a constant low and only the enables move.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_low_q <= 1'b0;
            byte_q <= 8'h00;
            valid_q <= 1'b0;
            user_q <= 1'b0;
            drive_q <= 2'h0;
            busy_q <= 1'b1;
        end else begin
            pin_low_q <= 1'b0;
            busy_q <= (seq_q != S_IDLE);
            valid_q <= byte_end && kind_q == K_DATA;
            if (byte_end && kind_q == K_DATA) begin
                byte_q <= rx_q;
                user_q <= (seq_q == S_EEU);
            end
            drive_q <= (eng_q != E_IDLE) ? cfg_q[`F_DRV] : 2'h0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign scl_out = pin_low_q;
    assign scl_oe = scl_low_q;
    assign serial_data_pin_out = pin_low_q;
    assign serial_data_pin_oe = sda_drv_q;
    assign pad_drive = drive_q;
    assign cfg_byte = byte_q;
    assign cfg_byte_valid = valid_q;
    assign cfg_stage_user = user_q;
    assign load_busy = busy_q;
    assign irq = irq_q;

    // ************************************************************
    // Checks.
    // ************************************************************
    scl_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
        (eng_q == E_BIT && rd && !fl) |=> !scl_oe)
        else $error("SCL not released at rise point.");
    scl_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
        (eng_q == E_BIT && fl) |=> scl_oe)
        else $error("SCL not pulled low at fall point.");
    sda_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        (eng_q == E_WAIT_SDA && !sda_s_q) |=> (eng_q == E_WAIT_SDA && !tif.run))
        else $error("Read started while data line low.");
    drive_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (eng_q == E_IDLE) |=> (pad_drive == 2'h0))
        else $error("Pad drive applied while master idle.");
    crc_sat_a: assert property (@(posedge pclk) disable iff (!presetn)
        (errcnt_q == `ERRCNT_MAX && !(wr_en && hit_cnt)) |=> (errcnt_q == `ERRCNT_MAX))
        else $error("CRC error counter wrapped.");
    nack_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (done_q && nack_q && last_try) |=> (ev_q[`EV_BAD] && !$past(ev_set[`EV_FAIL])))
        else $error("No-acknowledge not flagged as not detected.");
    order_a: assert property (@(posedge pclk) disable iff (!presetn)
        (seq_q == S_OTPC && !otp_common_valid) |=> (seq_q == S_OTPC))
        else $error("EEPROM common load before OTP common.");
    retry_a: assert property (@(posedge pclk) disable iff (!presetn)
        (done_q && fail && !last_try) |=> (go_q && attempt_q == $past(attempt_q) + 4'h1))
        else $error("Failed attempt not retried.");
endmodule

// [logic/scl_timer.sv]
`timescale 1ns/1ps
`include "eeprom_loader_params.svh"
module scl_timer (
    input wire logic pclk,
    input wire logic presetn,
    scl_timing_if.timer t
);
    import eeprom_loader_pkg::*;

    logic [11:0] cnt_q;
    logic [11:0] per_eff;
    logic [11:0] rise_eff;
    logic [11:0] fall_eff;

    // The faster speeds reuse the 100 kHz counts scaled down by a fixed divisor.
    function automatic logic [11:0] scale(input logic [11:0] v, input logic [1:0] spd);
        logic [11:0] r;
        r = v;
        if (spd == `SPEED_400K) begin
            r = v / `DIV_400K;
        end else if (spd == `SPEED_1M) begin
            r = v / `DIV_1M;
        end
        return r;
    endfunction

    assign per_eff = scale(t.cycle, t.speed);
    assign rise_eff = scale(t.rise, t.speed);
    assign fall_eff = scale(t.fall, t.speed);

    // Edge events fire when the down counter meets the programmed points.
    assign t.rise_ev = t.run && (cnt_q == rise_eff);
    assign t.fall_ev = t.run && (cnt_q == fall_eff);
    assign t.wrap_ev = t.run && (cnt_q == 12'h001);

    // Counter is parked at the period while idle, so each transfer starts on a full period.
    // It runs from the period down to one, so one SCL period spans exactly the speed-scaled count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 12'h000;
        end else if (!t.run || cnt_q <= 12'h001) begin
            cnt_q <= per_eff;
        end else begin
            cnt_q <= cnt_q - 12'h001;
        end
    end

    scl_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
        (t.run && cnt_q <= 12'h001) |=> (cnt_q == $past(per_eff)))
        else $error("SCL period counter did not reload.");
    fast_speed_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!t.run && t.speed == `SPEED_400K && $stable(t.cycle)) |=> (cnt_q == $past(t.cycle) / `DIV_400K))
        else $error("400 kHz period not divided by four.");
endmodule

// [verification/eeprom_model.sv]
`timescale 1ns/1ps
// Serial memory that answers every read with a byte ramp starting at 3C.
module eeprom_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic present,
    output logic sda_oe = 1'b0
);
    int n = 0;
    logic rd = 0, hdr = 0, ak = 0;
    logic [7:0] d = 8'h3C;
    // A start arms a control byte; a stop rewinds the ramp.
    always @(negedge sda) if (scl) begin
        n = 0;
        hdr = 1;
    end
    always @(posedge sda) if (scl) d = 8'h3C;
    // Bits are taken on the rising edge; a refused data byte ends the read.
    always @(posedge scl) if (n == 8) begin
        n = 0;
        d = d + (rd && !ak);
        rd = rd && (ak || !sda);
        ak = !rd; // After a slot the memory acknowledges writes but transmits on reads.
    end else begin
        n = n + 1;
        ak = hdr || !rd;
        rd = (hdr && n == 8) ? sda : rd;
        hdr = hdr && n < 8;
    end
    // Change the drive only as the clock falls, so data never moves under a high clock.
    always @(negedge scl) sda_oe = present && (n == 8 ? ak : rd && !ak && !d[7 - n]);
endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ps
`include "eeprom_loader_params.svh"
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 8'h00, cb;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic ocv = 0, ouv = 0, oen = 0, crc = 0, present = 1, m_oe, scl_oe, sd_oe, bv, su, busy, irq, er;
    logic hold = 0, scl_lvl, sdo;
    logic [1:0] pad_drive;
    int n_fail = 0, check_count = 0, nb[2] = '{0, 0};
    time t;
    // The data line has a pull-up, so a released line reads high.
    // The bench can hold the line low to stall the start of a read.
    wire sda = !(sd_oe || m_oe || hold);
    always #20 pclk = !pclk;
    eeprom_config_loader uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .otp_common_valid(ocv), .otp_user_valid(ouv), .otp_load_en(oen), .crc_bad(crc), .scl_out(scl_lvl),
        .scl_oe(scl_oe), .serial_data_pin_in(sda), .serial_data_pin_out(sdo), .serial_data_pin_oe(sd_oe),
        .pad_drive(pad_drive), .cfg_byte(cb), .cfg_byte_valid(bv), .cfg_stage_user(su), .load_busy(busy), .irq(irq));
    eeprom_model mdl (.scl(!scl_oe), .sda(sda), .present(present), .sda_oe(m_oe));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(r, e);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Each delivered byte must follow the memory's ramp within its stage.
    always @(posedge pclk) if (bv === 1'b1) begin
        chk(cb, 8'h3C + nb[su]);
        nb[su]++;
    end
    // Startup load with a short bit time, then a refused dynamic load.
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        rdc(`ADDR_CFG_LO, 32'h2580_0A04);
        rdc(`ADDR_CFG_HI, 32'h0009_61C2);
        rdc(`ADDR_TGT, 32'h50);
        apb(0, 8'h1C, 0);
        chk(er, 1);
        apb(1, `ADDR_CFG_HI, 32'h0000_2006);
        apb(1, `ADDR_CFG_LO, 32'h0080_2801);
        apb(1, `ADDR_MASK, 32'hB);
        oen <= 1;
        ocv <= 1;
        @(posedge pclk) ocv <= 0;
        repeat (40) @(posedge pclk);
        chk(pad_drive, 1);
        @(negedge scl_oe);
        t = $time;
        @(posedge scl_oe);
        chk(32'(($time - t) / 40), 4);
        t = $time;
        @(posedge scl_oe);
        chk(32'(($time - t) / 40), 8);
        for (int i = 0; i < 9000 && nb[0] < 64; i++) @(posedge pclk);
        chk(nb[0], 64);
        repeat (50) @(posedge pclk);
        crc <= 1;
        ouv <= 1;
        @(posedge pclk) ouv <= 0;
        for (int i = 0; i < 9000 && busy !== 1'b0; i++) @(posedge pclk);
        chk(nb[1], 64);
        rdc(`ADDR_EVENT, 32'h3);
        rdc(`ADDR_ERRCNT, 32'h1);
        chk(irq, 1);
        chk(pad_drive, 0);
        chk({scl_lvl, sdo}, 0);
        crc <= 0;
        present <= 0;
        apb(1, `ADDR_EVENT, 32'hF);
        rdc(`ADDR_EVENT, 32'h0);
        chk(irq, 0);
        // Dynamic load at 400 kHz with two tries against an absent memory.
        apb(1, `ADDR_CFG_HI, 32'h0000_8018);
        apb(1, `ADDR_CFG_LO, 32'h0200_2012);
        apb(1, `ADDR_CTRL, 32'h1);
        hold <= 1;
        ocv <= 1;
        @(posedge pclk) ocv <= 0;
        repeat (20) @(posedge pclk);
        rdc(`ADDR_CTRL, 32'h6);
        chk({scl_oe, sd_oe}, 0);
        hold <= 0;
        @(negedge scl_oe);
        t = $time;
        @(posedge scl_oe);
        chk(32'(($time - t) / 40), 4);
        for (int i = 0; i < 9000 && irq !== 1'b1; i++) @(posedge pclk);
        rdc(`ADDR_EVENT, 32'h8);
        oen <= 0;
        ouv <= 1;
        @(posedge pclk) ouv <= 0;
        repeat (2) @(posedge pclk);
        chk(busy, 0);
        rdc(`ADDR_CFG_LO, 32'h0200_2012);
        wrap_up;
    end
    // The run needs some 10000 cycles; a hang is cut off well after that.
    initial begin
        #2000000;
        n_fail++;
        wrap_up;
    end
endmodule
